// file: verilog/deep_sleep_clock_control.sv
// Low-power clock state sequencer with L2 clock gating and clock mode detection.
`timescale 1ns/1ns
`default_nettype none
`include "deep_sleep_clock_control_regs.svh"

module deep_sleep_clock_control
#(
    parameter int unsigned                 PLL_SETTLE_CYCLES = `PLL_SETTLE_US * `CORE_CLK_MHZ,
    parameter logic [`VOLT_CODE_WIDTH-1:0] VOLTAGE_CODE      = `VOLT_CODE_DEFAULT
)
(
    // Clock, reset and enable
    input  wire logic                         core_clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         ce_i,
    // Platform pins
    input  wire deep_sleep_pkg::bus_pins_t    pins_i,
    input  wire logic                         bus_clk_i,
    input  wire logic                         bus_clk_comp_i,
    // Core events
    input  wire logic                         halt_i,
    input  wire logic                         wake_i,
    input  wire logic                         irq_clear_i,
    input  wire logic                         violation_clear_i,
    // Voltage select open-drain pins
    input  wire logic [`VOLT_CODE_WIDTH-1:0]  voltage_select_code_i,
    output logic [`VOLT_CODE_WIDTH-1:0]       voltage_select_code_o,
    output logic [`VOLT_CODE_WIDTH-1:0]       voltage_select_code_oe_o,
    // Status
    output deep_sleep_pkg::power_state_t      state_o,
    output logic                              l2_clk_en_o,
    output logic                              snoop_ack_o,
    output logic [1:0]                        irq_pending_o,
    output logic                              diff_mode_o,
    output logic                              protocol_violation_o
);

    deep_sleep_pkg::bus_pins_t    pins_s1;
    deep_sleep_pkg::bus_pins_t    pins_s2;
    deep_sleep_pkg::bus_pins_t    pins_last;
    deep_sleep_pkg::power_state_t state;
    deep_sleep_pkg::power_state_t next_state;
    deep_sleep_pkg::power_state_t snoop_return;
    logic                         ret_halt;
    logic [`SETTLE_CNT_WIDTH-1:0] settle_cnt;
    logic                         true_active;
    logic                         comp_active;

    function automatic logic is_low_power(input deep_sleep_pkg::power_state_t s);
        is_low_power = (s == deep_sleep_pkg::ST_SLEEP) || (s == deep_sleep_pkg::ST_DEEP_SLEEP) ||
                       (s == deep_sleep_pkg::ST_PLL_SETTLE);
    endfunction : is_low_power

    function automatic logic l2_clock_on(input deep_sleep_pkg::power_state_t s);
        l2_clock_on = (s != deep_sleep_pkg::ST_DEEP_SLEEP) && (s != deep_sleep_pkg::ST_PLL_SETTLE);
    endfunction : l2_clock_on

    clk_activity_detect u_true_detect
    (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .pin_i      (bus_clk_i),
        .active_o   (true_active)
    );

    clk_activity_detect u_comp_detect
    (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .pin_i      (bus_clk_comp_i),
        .active_o   (comp_active)
    );

    // In differential mode the clock only counts as running when both halves toggle.
    wire bus_clk_active = diff_mode_o ? (true_active & comp_active) : true_active;
    wire stop_req       = ~pins_s2.stop_clock_request_n;
    wire sleep_req      = ~pins_s2.sleep_request_n;
    wire settle_done    = (settle_cnt == `SETTLE_CNT_WIDTH'(PLL_SETTLE_CYCLES - 1));
    wire pins_moved     = (pins_s2 != pins_last);
    wire irq_allowed    = ~is_low_power(state);
    wire [1:0] irq_set  = irq_allowed ? pins_s2.irq : 2'h0;
    wire viol_set       = pins_moved && (state == deep_sleep_pkg::ST_DEEP_SLEEP ||
                                         state == deep_sleep_pkg::ST_PLL_SETTLE);

    always_comb
    begin
        next_state = state;
        unique case (state)
            deep_sleep_pkg::ST_NORMAL:
            begin
                if (stop_req)
                    next_state = deep_sleep_pkg::ST_STOP_GRANT;
                else if (halt_i)
                    next_state = deep_sleep_pkg::ST_HALT;
            end
            deep_sleep_pkg::ST_HALT:
            begin
                if (stop_req)
                    next_state = deep_sleep_pkg::ST_STOP_GRANT;
                else if (pins_s2.snoop_req)
                    next_state = deep_sleep_pkg::ST_SNOOP;
                else if (wake_i)
                    next_state = deep_sleep_pkg::ST_NORMAL;
            end
            deep_sleep_pkg::ST_STOP_GRANT:
            begin
                if (sleep_req)
                    next_state = deep_sleep_pkg::ST_SLEEP;
                else if (!stop_req)
                    next_state = ret_halt ? deep_sleep_pkg::ST_HALT : deep_sleep_pkg::ST_NORMAL;
                else if (pins_s2.snoop_req)
                    next_state = deep_sleep_pkg::ST_SNOOP;
            end
            deep_sleep_pkg::ST_SNOOP:
            begin
                if (pins_s2.snoop_done)
                    next_state = snoop_return;
            end
            deep_sleep_pkg::ST_SLEEP:
            begin
                if (!bus_clk_active)
                    next_state = deep_sleep_pkg::ST_DEEP_SLEEP;
                else if (!sleep_req)
                    next_state = deep_sleep_pkg::ST_STOP_GRANT;
            end
            deep_sleep_pkg::ST_DEEP_SLEEP:
            begin
                if (bus_clk_active)
                    next_state = deep_sleep_pkg::ST_PLL_SETTLE;
            end
            deep_sleep_pkg::ST_PLL_SETTLE:
            begin
                if (!bus_clk_active)
                    next_state = deep_sleep_pkg::ST_DEEP_SLEEP;
                else if (settle_done)
                    next_state = deep_sleep_pkg::ST_SLEEP;
            end
            default:
            begin
                next_state = deep_sleep_pkg::ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            pins_s1   <= `PINS_IDLE;
            pins_s2   <= `PINS_IDLE;
            pins_last <= `PINS_IDLE;
        end
        else if (ce_i)
        begin
            pins_s1   <= pins_i;
            pins_s2   <= pins_s1;
            pins_last <= pins_s2;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            state        <= deep_sleep_pkg::ST_NORMAL;
            state_o      <= deep_sleep_pkg::ST_NORMAL;
            snoop_return <= deep_sleep_pkg::ST_NORMAL;
            ret_halt     <= 1'b0;
            settle_cnt   <= '0;
        end
        else if (ce_i)
        begin
            state      <= next_state;
            state_o    <= next_state;
            settle_cnt <= (state == deep_sleep_pkg::ST_PLL_SETTLE) ? settle_cnt + 1'b1 : '0;
            if (next_state == deep_sleep_pkg::ST_SNOOP && state != deep_sleep_pkg::ST_SNOOP)
                snoop_return <= state;
            if (state == deep_sleep_pkg::ST_HALT || state == deep_sleep_pkg::ST_NORMAL)
                ret_halt <= (state == deep_sleep_pkg::ST_HALT);
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            l2_clk_en_o          <= 1'b1;
            snoop_ack_o          <= 1'b0;
            irq_pending_o        <= 2'h0;
            protocol_violation_o <= 1'b0;
            diff_mode_o          <= 1'b0;
        end
        else if (ce_i)
        begin
            l2_clk_en_o          <= l2_clock_on(next_state);
            snoop_ack_o          <= (state == deep_sleep_pkg::ST_SNOOP) && pins_s2.snoop_done;
            irq_pending_o        <= irq_set | (irq_pending_o & ~{2{irq_clear_i}});
            protocol_violation_o <= viol_set | (protocol_violation_o & ~violation_clear_i);
            diff_mode_o          <= comp_active;
        end
    end

    // Open-drain: a zero bit pulls the pin low, a one bit leaves it to the pull-up.
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            voltage_select_code_o    <= '0;
            voltage_select_code_oe_o <= '0;
        end
        else
        begin
            voltage_select_code_o    <= '0;
            voltage_select_code_oe_o <= ~VOLTAGE_CODE;
        end
    end

    property p_deep_on_stop;
        @(posedge core_clk_i) disable iff (rst_i)
        (state == deep_sleep_pkg::ST_SLEEP && !bus_clk_active && ce_i) |=> (state == deep_sleep_pkg::ST_DEEP_SLEEP);
    endproperty
    a_deep_on_stop: assert property (p_deep_on_stop) else $error("Sleep did not drop to deep sleep.");

    property p_no_skip_settle;
        @(posedge core_clk_i) disable iff (rst_i)
        (state == deep_sleep_pkg::ST_SLEEP) |-> ($past(state) != deep_sleep_pkg::ST_DEEP_SLEEP);
    endproperty
    a_no_skip_settle: assert property (p_no_skip_settle) else $error("Sleep reached without settling.");

    property p_release;
        @(posedge core_clk_i) disable iff (rst_i)
        (state == deep_sleep_pkg::ST_SLEEP && bus_clk_active && !sleep_req && ce_i)
            |=> (state == deep_sleep_pkg::ST_STOP_GRANT);
    endproperty
    a_release: assert property (p_release) else $error("Sleep release did not reach stop-grant.");

    property p_ack_only_snoop;
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(snoop_ack_o) |-> ($past(state) == deep_sleep_pkg::ST_SNOOP);
    endproperty
    a_ack_only_snoop: assert property (p_ack_only_snoop) else $error("Snoop answered outside snoop state.");

    property p_l2_tracks_state;
        @(posedge core_clk_i) disable iff (rst_i)
        l2_clk_en_o == l2_clock_on(state);
    endproperty
    a_l2_tracks_state: assert property (p_l2_tracks_state) else $error("L2 clock enable disagrees with state.");

    property p_l2_in_halt;
        @(posedge core_clk_i) disable iff (rst_i)
        (state inside {deep_sleep_pkg::ST_HALT, deep_sleep_pkg::ST_STOP_GRANT, deep_sleep_pkg::ST_SNOOP})
            |-> l2_clk_en_o;
    endproperty
    a_l2_in_halt: assert property (p_l2_in_halt) else $error("L2 clock stopped in halt or stop-grant.");

    property p_sleep_entry;
        @(posedge core_clk_i) disable iff (rst_i)
        (state == deep_sleep_pkg::ST_SLEEP && $past(state) != deep_sleep_pkg::ST_SLEEP)
            |-> ($past(state) inside {deep_sleep_pkg::ST_STOP_GRANT, deep_sleep_pkg::ST_PLL_SETTLE});
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep entered from a wrong state.");

    property p_stop_grant;
        @(posedge core_clk_i) disable iff (rst_i)
        (state == deep_sleep_pkg::ST_NORMAL && stop_req && ce_i) |=> (state == deep_sleep_pkg::ST_STOP_GRANT);
    endproperty
    a_stop_grant: assert property (p_stop_grant) else $error("Stop-clock request not honoured.");

    property p_voltage_code;
        @(posedge core_clk_i) disable iff (rst_i)
        !rst_i ##1 !rst_i |-> (voltage_select_code_oe_o == ~VOLTAGE_CODE) && (voltage_select_code_o == '0);
    endproperty
    a_voltage_code: assert property (p_voltage_code) else $error("Voltage select pins wrong.");

    property p_no_irq_latch;
        @(posedge core_clk_i) disable iff (rst_i)
        (is_low_power(state) && ce_i) |=> ((irq_pending_o & ~$past(irq_pending_o)) == 2'h0);
    endproperty
    a_no_irq_latch: assert property (p_no_irq_latch) else $error("Interrupt latched in a sleep state.");

    property p_viol_set;
        @(posedge core_clk_i) disable iff (rst_i)
        (viol_set && ce_i) |=> protocol_violation_o;
    endproperty
    a_viol_set: assert property (p_viol_set) else $error("Input change in deep sleep not flagged.");

    property p_l2_restart;
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(l2_clk_en_o) |-> (state == deep_sleep_pkg::ST_SLEEP);
    endproperty
    a_l2_restart: assert property (p_l2_restart) else $error("L2 clock restarted outside sleep.");

    property p_settle_len;
        @(posedge core_clk_i) disable iff (rst_i)
        (state == deep_sleep_pkg::ST_SLEEP && $past(state) == deep_sleep_pkg::ST_PLL_SETTLE)
            |-> ($past(settle_cnt) == `SETTLE_CNT_WIDTH'(PLL_SETTLE_CYCLES - 1));
    endproperty
    a_settle_len: assert property (p_settle_len) else $error("Sleep reached before settling ended.");

    property p_diff_stop;
        @(posedge core_clk_i) disable iff (rst_i)
        (state == deep_sleep_pkg::ST_SLEEP && diff_mode_o && !comp_active && ce_i)
            |=> (state == deep_sleep_pkg::ST_DEEP_SLEEP);
    endproperty
    a_diff_stop: assert property (p_diff_stop) else $error("Stopped complement clock not seen.");

endmodule : deep_sleep_clock_control
`default_nettype wire

// file: verilog/deep_sleep_clock_control_regs.svh
// Constants for the deep sleep clock control block.
`ifndef DEEP_SLEEP_CLOCK_CONTROL_REGS_SVH
`define DEEP_SLEEP_CLOCK_CONTROL_REGS_SVH

`define CORE_CLK_MHZ        100
`define PLL_SETTLE_US       1000
`define CLK_IDLE_CYCLES     8'h10
`define VOLT_CODE_WIDTH     5
`define VOLT_CODE_DEFAULT   5'h04
`define SETTLE_CNT_WIDTH    17
`define PINS_IDLE           6'h30

`endif

// file: verilog/deep_sleep_pkg.sv
// Types shared by the deep sleep clock control block.
package deep_sleep_pkg;

    typedef enum logic [2:0] {
        ST_NORMAL     = 3'h0,
        ST_STOP_GRANT = 3'h1,
        ST_SLEEP      = 3'h3,
        ST_DEEP_SLEEP = 3'h2,
        ST_PLL_SETTLE = 3'h6,
        ST_HALT       = 3'h4,
        ST_SNOOP      = 3'h5
    } power_state_t;

    typedef struct packed {
        logic       stop_clock_request_n;
        logic       sleep_request_n;
        logic       snoop_req;
        logic       snoop_done;
        logic [1:0] irq;
    } bus_pins_t;

endpackage : deep_sleep_pkg

// file: verilog/clk_activity_detect.sv
// Detects whether a clock pin is toggling, sampled on the core clock.
`timescale 1ns/1ns
`default_nettype none
`include "deep_sleep_clock_control_regs.svh"

module clk_activity_detect
(
    // Clock and control
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Monitored pin
    input  wire logic pin_i,
    // Activity flag
    output logic      active_o
);

    logic       sync1;
    logic       sync2;
    logic       last;
    logic [2:0] fill;
    logic [7:0] idle_cnt;
    // Edges count only once the pipeline holds real samples, so reset cannot fake one.
    wire        edge_seen = fill[2] & (sync2 ^ last);
    wire        idle_done = (idle_cnt == `CLK_IDLE_CYCLES);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            sync1    <= 1'b0;
            sync2    <= 1'b0;
            last     <= 1'b0;
            fill     <= 3'h0;
            idle_cnt <= `CLK_IDLE_CYCLES;
            active_o <= 1'b0;
        end
        else if (ce_i)
        begin
            sync1    <= pin_i;
            sync2    <= sync1;
            last     <= sync2;
            fill     <= {fill[1:0], 1'b1};
            idle_cnt <= edge_seen ? 8'h00 : (idle_done ? idle_cnt : idle_cnt + 8'h01);
            active_o <= edge_seen | ~idle_done;
        end
    end

endmodule : clk_activity_detect
`default_nettype wire

// file: bench/platform_model.sv
// Platform-side model driving the sleep pins and the bus clocks.
`timescale 1ns/1ns
`default_nettype none

module platform_model
(
    // Clock and controls from the bench
    input  wire logic                      core_clk_i,
    input  wire logic                      run_i,
    input  wire logic                      diff_i,
    input  wire deep_sleep_pkg::bus_pins_t req_i,
    // Pins towards the device
    output deep_sleep_pkg::bus_pins_t      pins_o,
    output logic                           bus_clk_o,
    output logic                           bus_clk_comp_o,
    output logic                           ictl_clk_o
);
    // The bus clock stands still while stopped and resumes from its last level.
    initial bus_clk_o = 1'b0;
    always @(posedge core_clk_i)
        if (run_i)
            bus_clk_o <= ~bus_clk_o;
    // Interrupt-controller clock follows the bus clock, so both restart together.
    assign ictl_clk_o     = bus_clk_o;
    assign bus_clk_comp_o = diff_i ? ~bus_clk_o : 1'b1;
    // Requests are levels that the bench holds for many bus clocks.
    assign pins_o         = req_i;
endmodule : platform_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking testbench for the deep sleep clock control block.
`timescale 1ns/1ns
`default_nettype none
`include "deep_sleep_clock_control_regs.svh"

module testbench;
    localparam int unsigned SETTLE = 20;
    localparam logic [4:0]  VCODE  = 5'h04;
    logic                        core_clk_i = 1'b0;
    logic                        rst_i = 1'b1;
    logic                        ce = 1'b1;
    logic                        run = 1'b1;
    logic                        diff = 1'b0;
    logic                        halt = 1'b0;
    logic                        wake = 1'b0;
    logic                        irq_clr = 1'b0;
    logic                        vio_clr = 1'b0;
    deep_sleep_pkg::bus_pins_t   req = 6'h30;
    deep_sleep_pkg::bus_pins_t   pins;
    wire logic                   bclk;
    wire logic                   bclk_n;
    wire logic [4:0]             vpin;
    logic [4:0]                  vo;
    logic [4:0]                  voe;
    deep_sleep_pkg::power_state_t st;
    logic                        l2;
    logic                        ack;
    logic [1:0]                  irqp;
    logic                        dm;
    logic                        vio;
    int                          num_errors = 0;
    int                          num_checks = 0;

    always #5 core_clk_i = ~core_clk_i;
    // Open-drain pins float high through the pull-up when not driven.
    assign vpin = (vo & voe) | ~voe;

    platform_model pm (.core_clk_i(core_clk_i), .run_i(run), .diff_i(diff), .req_i(req),
        .pins_o(pins), .bus_clk_o(bclk), .bus_clk_comp_o(bclk_n), .ictl_clk_o());

    deep_sleep_clock_control #(.PLL_SETTLE_CYCLES(SETTLE), .VOLTAGE_CODE(VCODE)) uut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce), .pins_i(pins),
        .bus_clk_i(bclk), .bus_clk_comp_i(bclk_n), .halt_i(halt), .wake_i(wake),
        .irq_clear_i(irq_clr), .violation_clear_i(vio_clr), .voltage_select_code_i(vpin),
        .voltage_select_code_o(vo), .voltage_select_code_oe_o(voe), .state_o(st),
        .l2_clk_en_o(l2), .snoop_ack_o(ack), .irq_pending_o(irqp), .diff_mode_o(dm),
        .protocol_violation_o(vio));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : tick

    task automatic wait_st(input deep_sleep_pkg::power_state_t s, input int lim, output int n);
        n = 0;
        while (st !== s && n < lim)
        begin
            tick(1);
            n++;
        end
        chk("state", 8'(s), 8'(st));
    endtask : wait_st

    task automatic t_reset;
        chk("state", 8'(deep_sleep_pkg::ST_NORMAL), 8'(st));
        chk("l2", 8'h01, 8'(l2));
        chk("vsel", 8'(VCODE), 8'(vpin));
        chk("vo", 8'h00, 8'(vo));
    endtask : t_reset

    task automatic t_sleep_ignored;
        int n;
        req.sleep_request_n = 1'b0;
        tick(8);
        chk("normal", 8'(deep_sleep_pkg::ST_NORMAL), 8'(st));
        halt = 1'b1;
        wait_st(deep_sleep_pkg::ST_HALT, 8, n);
        halt = 1'b0;
        tick(8);
        chk("halt", 8'(deep_sleep_pkg::ST_HALT), 8'(st));
        chk("l2", 8'h01, 8'(l2));
        req.sleep_request_n = 1'b1;
        req.irq = 2'h2;
        tick(6);
        chk("irq", 8'h02, 8'(irqp));
        req.irq = 2'h0;
        irq_clr = 1'b1;
        tick(1);
        irq_clr = 1'b0;
        chk("irq set wins", 8'h02, 8'(irqp));
        tick(3);
        irq_clr = 1'b1;
        tick(1);
        irq_clr = 1'b0;
        chk("irq clear", 8'h00, 8'(irqp));
        req.snoop_req = 1'b1;
        wait_st(deep_sleep_pkg::ST_SNOOP, 6, n);
        req.snoop_req = 1'b0;
        req.snoop_done = 1'b1;
        wait_st(deep_sleep_pkg::ST_HALT, 6, n);
        req.snoop_done = 1'b0;
        wake = 1'b1;
        wait_st(deep_sleep_pkg::ST_NORMAL, 8, n);
        wake = 1'b0;
    endtask : t_sleep_ignored

    task automatic t_snoop;
        int n;
        req.stop_clock_request_n = 1'b0;
        wait_st(deep_sleep_pkg::ST_STOP_GRANT, 6, n);
        req.snoop_req = 1'b1;
        wait_st(deep_sleep_pkg::ST_SNOOP, 6, n);
        chk("l2", 8'h01, 8'(l2));
        req.snoop_done = 1'b1;
        req.snoop_req = 1'b0;
        n = 0;
        while (ack !== 1'b1 && n < 8)
        begin
            tick(1);
            n++;
        end
        chk("ack", 8'h01, 8'(ack));
        req.snoop_done = 1'b0;
        wait_st(deep_sleep_pkg::ST_STOP_GRANT, 4, n);
    endtask : t_snoop

    task automatic t_deep_sleep;
        int n;
        req.sleep_request_n = 1'b0;
        wait_st(deep_sleep_pkg::ST_SLEEP, 6, n);
        tick(2);
        chk("l2", 8'h01, 8'(l2));
        run = 1'b0;
        wait_st(deep_sleep_pkg::ST_DEEP_SLEEP, 40, n);
        chk("l2", 8'h00, 8'(l2));
        req.irq = 2'h1;
        req.snoop_req = 1'b1;
        tick(6);
        chk("irq", 8'h00, 8'(irqp));
        chk("ack", 8'h00, 8'(ack));
        chk("vio", 8'h01, 8'(vio));
        req.irq = 2'h0;
        req.snoop_req = 1'b0;
        tick(4);
        vio_clr = 1'b1;
        tick(1);
        vio_clr = 1'b0;
        chk("vio", 8'h00, 8'(vio));
        run = 1'b1;
        wait_st(deep_sleep_pkg::ST_PLL_SETTLE, 8, n);
        chk("l2", 8'h00, 8'(l2));
        wait_st(deep_sleep_pkg::ST_SLEEP, 40, n);
        chk("settle", 8'(SETTLE), 8'(n));
        chk("l2", 8'h01, 8'(l2));
        req.sleep_request_n = 1'b1;
        wait_st(deep_sleep_pkg::ST_STOP_GRANT, 6, n);
        req.stop_clock_request_n = 1'b1;
        wait_st(deep_sleep_pkg::ST_NORMAL, 6, n);
    endtask : t_deep_sleep

    task automatic t_freeze;
        int n;
        ce = 1'b0;
        req.stop_clock_request_n = 1'b0;
        tick(8);
        chk("frozen", 8'(deep_sleep_pkg::ST_NORMAL), 8'(st));
        ce = 1'b1;
        wait_st(deep_sleep_pkg::ST_STOP_GRANT, 6, n);
        req.stop_clock_request_n = 1'b1;
        wait_st(deep_sleep_pkg::ST_NORMAL, 6, n);
    endtask : t_freeze

    task automatic t_diff;
        diff = 1'b1;
        tick(10);
        chk("diff", 8'h01, 8'(dm));
        diff = 1'b0;
        tick(30);
        chk("single", 8'h00, 8'(dm));
    endtask : t_diff

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    initial
    begin
        tick(12);
        rst_i = 1'b0;
        tick(6);
        t_reset();
        t_sleep_ignored();
        t_snoop();
        t_deep_sleep();
        t_freeze();
        t_diff();
        print_verdict();
    end

    initial
    begin
        #200000;
        num_errors++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
